// ===== hdl/alarm_cause_decode.sv
// Purpose: turn raw converter status into per-cycle alarm set requests
// Assumes: all inputs synchronous to the sample/link clock
// Notes: purely combinational
`timescale 1ns/100ps
`default_nettype none
module alarm_cause_decode #(
  parameter int LANES = 16
) (
  // lane fifo status
  input wire logic [LANES-1:0] lane_fifo_error,
  input wire logic [LANES-1:0] lane_active,
  // clocking and link status
  input wire logic pll_locked,
  input wire logic link_enable,
  input wire logic link_mode_66b,
  input wire logic link_data_state,
  input wire logic link_startup,
  input wire logic link_realign,
  input wire logic sysref_realign,
  input wire logic osc_sync,
  input wire logic osc_phase_mismatch,
  input wire logic divider_mismatch,
  // set requests
  output alarm_pkg::alarm_vec_t causes,
  output logic [LANES-1:0] lane_set
);
  import alarm_pkg::*;

  always_comb begin
    lane_set = lane_fifo_error & lane_active;
    causes.lane_buffer_error_flag = |lane_set;
    causes.lock_loss_flag = ~pll_locked;
    // the two encodings report link trouble differently
    if (link_mode_66b) begin
      causes.serial_link_flag = link_startup | link_realign;
    end else begin
      causes.serial_link_flag = link_enable & ~link_data_state;
    end
    causes.clock_realign_flag = sysref_realign;
    // with the link off the oscillator flag is held set and the 8b/10b link flag cannot set; the others keep running
    causes.oscillator_phase_flag = ~link_enable | osc_sync | osc_phase_mismatch;
    causes.divider_mismatch_flag = divider_mismatch;
  end

endmodule
`default_nettype wire

// ===== hdl/alarm_pkg.sv
// Purpose: constants and types for the converter alarm aggregator
// Assumes: byte-wide register port, 12-bit register addresses
// Notes: flag bit order is fifo, pll, link, realign, oscillator, clock (5..0)
//
// Functional notes
// - summary bit is high whenever any unmasked status flag is set
// - selected by the status select, the summary drives the calibration status pin
// - fifo flag (bit 5) sets on underflow or overflow of any active lane
// - flags are sticky; writing one to a bit clears that flag
// - lock loss flag (bit 4) sets whenever the pll is not locked
// - 8b/10b: link flag (bit 3) sets while enabled but not in data state
// - 64b/66b: link flag sets at link start-up and on any realignment
// - realign flag (bit 2) sets whenever sysref realigns the internal clocks
// - oscillator flag (bit 1) sets when link disabled, synchronised, or phases differ
// - clock flag (bit 0) sets whenever channel a and b dividers disagree
// - after power-on or soft reset all six flags read set, value 0x3F
// - with link disabled non-clock flags are undefined; software clears after enabling
// - six mask bits, all set after reset, exclude their flag from the summary
// - 16-bit per-lane error vector, write-one clears, fifo flag clear clears all
package alarm_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int FLAG_N = 6;
  localparam int LANE_N = 16;

  localparam logic [ADDR_W-1:0] ADDR_SUMMARY = 12'h2C0;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS = 12'h2C1;
  localparam logic [ADDR_W-1:0] ADDR_DISABLES = 12'h2C2;
  localparam logic [ADDR_W-1:0] ADDR_LANES_LO = 12'h2C4;
  localparam logic [ADDR_W-1:0] ADDR_LANES_HI = 12'h2C5;

  localparam int BIT_FIFO = 5;
  localparam int BIT_PLL = 4;
  localparam int BIT_LINK = 3;
  localparam int BIT_REALIGN = 2;
  localparam int BIT_OSC = 1;
  localparam int BIT_CLK = 0;

  localparam logic [FLAG_N-1:0] FLAGS_RESET = 6'h3F;
  localparam logic [FLAG_N-1:0] DISABLES_RESET = 6'h3F;
  localparam logic [LANE_N-1:0] LANES_RESET = 16'hFFFF;

  // one bit per alarm source, same order as the status register
  typedef struct packed {
    logic lane_buffer_error_flag;
    logic lock_loss_flag;
    logic serial_link_flag;
    logic clock_realign_flag;
    logic oscillator_phase_flag;
    logic divider_mismatch_flag;
  } alarm_vec_t;

  // one register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

endpackage

// ===== hdl/converter_alarm_aggregator.sv
// Purpose: sticky alarm flags, masks, summary bit and status pin routing
// Assumes: byte-wide register port on clk; all status inputs synchronous to clk
// Notes: read data appears one cycle after the read strobe; writes act at once
`timescale 1ns/100ps
`default_nettype none
module converter_alarm_aggregator #(
  parameter int LANES = alarm_pkg::LANE_N
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic soft_reset,
  // register port
  input wire alarm_pkg::reg_req_t reg_req,
  output logic [alarm_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  // lane fifo status
  input wire logic [LANES-1:0] lane_fifo_error,
  input wire logic [LANES-1:0] lane_active,
  // clocking and link status
  input wire logic pll_locked,
  input wire logic link_enable,
  input wire logic link_mode_66b,
  input wire logic link_data_state,
  input wire logic link_startup,
  input wire logic link_realign,
  input wire logic sysref_realign,
  input wire logic osc_sync,
  input wire logic osc_phase_mismatch,
  input wire logic divider_mismatch,
  // calibration status pin
  input wire logic calibration_status_sel,
  input wire logic calibration_status_in,
  output logic calibration_status_pin,
  output logic alarm_summary
);
  import alarm_pkg::*;

  alarm_vec_t causes;
  logic [LANES-1:0] lane_set;
  logic [FLAG_N-1:0] alarm_flags_r;
  logic [FLAG_N-1:0] alarm_flag_disables_r;
  logic [LANES-1:0] per_lane_buffer_errors_r;
  logic [FLAG_N-1:0] flag_clr;
  logic [LANES-1:0] lane_clr;
  logic [DATA_W-1:0] rdata_nxt;
  logic wr_flags;
  logic wr_lo;
  logic wr_hi;

  // address match shared by read and write paths
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ref_addr);
    hit = (a == ref_addr);
  endfunction

  alarm_cause_decode #(
    .LANES(LANES)
  ) u_decode (
    .lane_fifo_error(lane_fifo_error),
    .lane_active(lane_active),
    .pll_locked(pll_locked),
    .link_enable(link_enable),
    .link_mode_66b(link_mode_66b),
    .link_data_state(link_data_state),
    .link_startup(link_startup),
    .link_realign(link_realign),
    .sysref_realign(sysref_realign),
    .osc_sync(osc_sync),
    .osc_phase_mismatch(osc_phase_mismatch),
    .divider_mismatch(divider_mismatch),
    .causes(causes),
    .lane_set(lane_set)
  );

  // write decode
  always_comb begin
    wr_flags = reg_req.wr && hit(reg_req.addr, ADDR_FLAGS);
    wr_lo = reg_req.wr && hit(reg_req.addr, ADDR_LANES_LO);
    wr_hi = reg_req.wr && hit(reg_req.addr, ADDR_LANES_HI);
    flag_clr = wr_flags ? reg_req.wdata[FLAG_N-1:0] : '0;
    lane_clr = '0;
    if (wr_lo) begin
      lane_clr[7:0] = reg_req.wdata;
    end
    if (wr_hi) begin
      lane_clr[LANES-1:8] = reg_req.wdata[LANES-9:0];
    end
    // clearing the fifo flag also empties the per-lane record
    if (wr_flags && reg_req.wdata[BIT_FIFO]) begin
      lane_clr = '1;
    end
  end

  sticky_bits #(
    .W(FLAG_N),
    .RESET_VAL(FLAGS_RESET)
  ) u_flags (
    .clk(clk),
    .rstn(rstn),
    .reload(soft_reset),
    .set_vec(causes),
    .clr_vec(flag_clr),
    .bits_r(alarm_flags_r)
  );

  sticky_bits #(
    .W(LANES),
    .RESET_VAL(LANES_RESET)
  ) u_lanes (
    .clk(clk),
    .rstn(rstn),
    .reload(soft_reset),
    .set_vec(lane_set),
    .clr_vec(lane_clr),
    .bits_r(per_lane_buffer_errors_r)
  );

  // mask register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      alarm_flag_disables_r <= DISABLES_RESET;
    end else if (soft_reset) begin
      alarm_flag_disables_r <= DISABLES_RESET;
    end else if (reg_req.wr && hit(reg_req.addr, ADDR_DISABLES)) begin
      alarm_flag_disables_r <= reg_req.wdata[FLAG_N-1:0];
    end
  end

  // summary follows flag state with no extra delay, so the pin tracks a clear at once when calibration_status_sel picks the summary
  always_comb begin
    alarm_summary = |(alarm_flags_r & ~alarm_flag_disables_r);
    calibration_status_pin = calibration_status_sel ? alarm_summary : calibration_status_in;
  end

  // read path; unmapped addresses read zero
  always_comb begin
    rdata_nxt = '0;
    if (hit(reg_req.addr, ADDR_SUMMARY)) begin
      rdata_nxt[0] = alarm_summary;
    end else if (hit(reg_req.addr, ADDR_FLAGS)) begin
      rdata_nxt[FLAG_N-1:0] = alarm_flags_r;
    end else if (hit(reg_req.addr, ADDR_DISABLES)) begin
      rdata_nxt[FLAG_N-1:0] = alarm_flag_disables_r;
    end else if (hit(reg_req.addr, ADDR_LANES_LO)) begin
      rdata_nxt = per_lane_buffer_errors_r[7:0];
    end else if (hit(reg_req.addr, ADDR_LANES_HI)) begin
      rdata_nxt = per_lane_buffer_errors_r[LANES-1:8];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= '0;
    end else if (reg_req.rd) begin
      reg_rdata <= rdata_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd;
    end
  end

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  logic [FLAG_N-1:0] clr_only;
  always_comb begin
    clr_only = flag_clr & ~causes;
  end

  // lane bits a write would clear, less those a new lane error keeps set
  logic [LANES-1:0] lane_clr_only;
  always_comb begin
    lane_clr_only = lane_clr & ~lane_set;
  end

  sequence s_read_at(logic [ADDR_W-1:0] a);
    reg_req.rd && hit(reg_req.addr, a);
  endsequence

  sequence s_flag_write;
    wr_flags && !soft_reset;
  endsequence

  sequence s_fifo_clear_quiet;
    s_flag_write ##0 reg_req.wdata[BIT_FIFO] && lane_set == '0;
  endsequence

  a_summary_level: assert property (
    alarm_flag_disables_r == '0 && alarm_flags_r != '0 |-> alarm_summary)
    else $error("summary bit low with unmasked flags set");

  a_summary_readback: assert property (
    reg_req.rd && hit(reg_req.addr, ADDR_SUMMARY) |=> reg_rvalid && reg_rdata == {7'h00, $past(alarm_summary)})
    else $error("summary read returned wrong value");

  a_pin_route: assert property (
    calibration_status_sel |-> calibration_status_pin == alarm_summary)
    else $error("status pin does not carry summary");

  a_fifo_set: assert property (
    |(lane_fifo_error & lane_active) && !soft_reset |=> alarm_flags_r[BIT_FIFO]
      && (per_lane_buffer_errors_r & $past(lane_set)) == $past(lane_set))
    else $error("lane error did not set fifo flag");

  a_flag_clear: assert property (
    s_flag_write |=> (alarm_flags_r & $past(clr_only)) == '0)
    else $error("write one did not clear flag");

  a_pll_set: assert property (
    !pll_locked && !soft_reset |=> alarm_flags_r[BIT_PLL])
    else $error("lock loss not flagged");

  a_link_8b: assert property (
    !link_mode_66b && link_enable && !link_data_state && !soft_reset |=> alarm_flags_r[BIT_LINK])
    else $error("8b10b link alarm missing");

  a_link_66b: assert property (
    link_mode_66b && (link_startup || link_realign) && !soft_reset |=> alarm_flags_r[BIT_LINK])
    else $error("64b66b link alarm missing");

  a_realign_set: assert property (
    sysref_realign && !soft_reset |=> alarm_flags_r[BIT_REALIGN])
    else $error("realign alarm missing");

  a_osc_set: assert property (
    (!link_enable || osc_sync || osc_phase_mismatch) && !soft_reset |=> alarm_flags_r[BIT_OSC])
    else $error("oscillator alarm missing");

  a_clk_set: assert property (
    divider_mismatch && !soft_reset |=> alarm_flags_r[BIT_CLK])
    else $error("divider mismatch alarm missing");

  a_soft_reload: assert property (
    soft_reset |=> alarm_flags_r == FLAGS_RESET && alarm_flag_disables_r == DISABLES_RESET
      && per_lane_buffer_errors_r == LANES_RESET)
    else $error("soft reset did not restore defaults");

  a_mask_excludes: assert property (
    reg_req.wr && hit(reg_req.addr, ADDR_DISABLES) && (&reg_req.wdata[FLAG_N-1:0]) && !soft_reset
      |=> !alarm_summary)
    else $error("masked flag reached summary");

  a_lane_wipe: assert property (
    s_fifo_clear_quiet |=> per_lane_buffer_errors_r == '0)
    else $error("fifo flag clear left lane bits");

  a_set_wins: assert property (
    s_flag_write ##0 (causes & reg_req.wdata[FLAG_N-1:0]) != '0
      |=> (alarm_flags_r & $past(causes)) == $past(causes))
    else $error("clear overrode a present condition");

  a_summary_quiet: assert property (
    alarm_flags_r == '0 |-> !alarm_summary)
    else $error("summary bit high with no flag set");

  a_pin_bypass: assert property (
    !calibration_status_sel |-> calibration_status_pin == calibration_status_in)
    else $error("status pin lost its other source");

  a_inactive_lane: assert property (
    (lane_fifo_error & lane_active) == '0 && !soft_reset
      |=> (per_lane_buffer_errors_r & ~$past(per_lane_buffer_errors_r)) == '0)
    else $error("inactive lane error was recorded");

  a_flags_readback: assert property (
    s_read_at(ADDR_FLAGS) |=> reg_rvalid && reg_rdata == {2'b00, $past(alarm_flags_r)})
    else $error("flag read returned wrong value");

  a_mask_readback: assert property (
    s_read_at(ADDR_DISABLES) |=> reg_rvalid && reg_rdata == {2'b00, $past(alarm_flag_disables_r)})
    else $error("mask read returned wrong value");

  a_lanes_lo_read: assert property (
    s_read_at(ADDR_LANES_LO) |=> {8'h00, reg_rdata} == ($past(per_lane_buffer_errors_r) & 16'h00FF))
    else $error("low lane byte read wrong");

  a_lanes_hi_read: assert property (
    s_read_at(ADDR_LANES_HI) |=> {reg_rdata, 8'h00} == ($past(per_lane_buffer_errors_r) & 16'hFF00))
    else $error("high lane byte read wrong");

  a_mask_write: assert property (
    reg_req.wr && hit(reg_req.addr, ADDR_DISABLES) && !soft_reset
      |=> {2'b00, alarm_flag_disables_r} == ($past(reg_req.wdata) & 8'h3F))
    else $error("mask write did not land");

  a_flag_hold: assert property (
    causes == '0 && !wr_flags && !soft_reset |=> alarm_flags_r == $past(alarm_flags_r))
    else $error("flag changed with no set or clear");

  a_lane_clear: assert property (
    reg_req.wr && !soft_reset |=> (per_lane_buffer_errors_r & $past(lane_clr_only)) == '0)
    else $error("lane write one did not clear");

  a_lane_hold: assert property (
    lane_set == '0 && lane_clr == '0 && !soft_reset
      |=> per_lane_buffer_errors_r == $past(per_lane_buffer_errors_r))
    else $error("lane bit changed with no set or clear");

  a_lane_set_wins: assert property (
    (lane_set & lane_clr) != '0 && !soft_reset
      |=> (per_lane_buffer_errors_r & $past(lane_set)) == $past(lane_set))
    else $error("lane clear overrode a lane error");

endmodule
`default_nettype wire

// ===== hdl/sticky_bits.sv
// Purpose: bank of sticky bits, set by hardware, cleared by writing one
// Assumes: set, clear and reload are single-cycle requests
// Notes: set wins over clear so no event is lost
`timescale 1ns/100ps
`default_nettype none
module sticky_bits #(
  parameter int W = 6,
  parameter logic [W-1:0] RESET_VAL = '1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // requests
  input wire logic reload,
  input wire logic [W-1:0] set_vec,
  input wire logic [W-1:0] clr_vec,
  // state
  output logic [W-1:0] bits_r
);

  logic [W-1:0] bits_nxt;

  always_comb begin
    bits_nxt = (bits_r & ~clr_vec) | set_vec;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bits_r <= RESET_VAL;
    end else if (reload) begin
      bits_r <= RESET_VAL;
    end else begin
      bits_r <= bits_nxt;
    end
  end

endmodule
`default_nettype wire

// ===== sim/converter_alarm_aggregator_tb.sv
// Purpose: self-checking bench for the converter alarm aggregator
// Assumes: inputs change on the falling edge; read data checked when reg_rvalid pulses
// Notes: expected read values are queued by the driver and popped by the monitor
`timescale 1ns/100ps
`default_nettype none
module converter_alarm_aggregator_tb;
  import alarm_pkg::*;
  logic clk, rstn, soft_reset;
  reg_req_t reg_req;
  logic [DATA_W-1:0] reg_rdata;
  logic reg_rvalid;
  logic [LANE_N-1:0] lane_fifo_error, lane_active, lanes, err_pat;
  logic pll_locked, link_enable, link_mode_66b, link_data_state, link_startup, link_realign;
  logic sysref_realign, osc_sync, osc_phase_mismatch, divider_mismatch;
  logic calibration_status_sel, calibration_status_in, calibration_status_pin, alarm_summary;
  int err_count, n_tests, lane, k;
  int flag_bit[10] = '{5, 4, 3, 2, 1, 0, 1, 1, 3, 3};
  logic [DATA_W-1:0] exp_q[$];
  logic [ADDR_W-1:0] adr_q[$];

  converter_alarm_aggregator converter_alarm_aggregator_inst (
    .clk, .rstn, .soft_reset, .reg_req, .reg_rdata, .reg_rvalid, .lane_fifo_error, .lane_active,
    .pll_locked, .link_enable, .link_mode_66b, .link_data_state, .link_startup, .link_realign,
    .sysref_realign, .osc_sync, .osc_phase_mismatch, .divider_mismatch, .calibration_status_sel,
    .calibration_status_in, .calibration_status_pin, .alarm_summary
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task end_sim;
    if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge clk);
    reg_req = '{1'b1, 1'b0, a, d};
    @(negedge clk);
    reg_req = '0;
  endtask

  task rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(negedge clk);
    reg_req = '{1'b0, 1'b1, a, 8'h00};
    exp_q.push_back(e);
    adr_q.push_back(a);
    @(negedge clk);
    reg_req = '0;
  endtask

  task sreset;
    @(negedge clk);
    soft_reset = 1'b1;
    @(negedge clk);
    soft_reset = 1'b0;
  endtask

  // one cause per index; index 8 and 9 briefly switch to 64b/66b
  task cause(input int i, input logic on);
    case (i)
      0: lane_fifo_error = on ? err_pat : 16'h0000;
      1: pll_locked = !on;
      2: link_data_state = !on;
      3: sysref_realign = on;
      4: osc_phase_mismatch = on;
      5: divider_mismatch = on;
      6: osc_sync = on;
      7: link_enable = !on;
      8: begin
        link_mode_66b = on;
        link_startup = on;
      end
      default: begin
        link_mode_66b = on;
        link_realign = on;
      end
    endcase
  endtask

  always @(negedge clk) begin
    if (reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) chk("unrequested read", 16'h0000, {8'h00, reg_rdata});
      else chk($sformatf("read %h", adr_q.pop_front()), {8'h00, exp_q.pop_front()}, {8'h00, reg_rdata});
    end
  end

  initial begin
    err_count = 0;
    n_tests = 0;
    rstn = 1'b0;
    soft_reset = 1'b0;
    reg_req = '0;
    lane_fifo_error = 16'h0000;
    lane_active = 16'hFFFF;
    lanes = 16'h0000;
    err_pat = 16'h0000;
    {pll_locked, link_enable, link_data_state} = 3'h7;
    {link_mode_66b, link_startup, link_realign, sysref_realign} = 4'h0;
    {osc_sync, osc_phase_mismatch, divider_mismatch} = 3'h0;
    calibration_status_sel = 1'b1;
    calibration_status_in = 1'b0;
    void'($urandom(80616));
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    rd(ADDR_FLAGS, 8'h3F);
    rd(ADDR_DISABLES, 8'h3F);
    rd(ADDR_SUMMARY, 8'h00);
    rd(ADDR_LANES_LO, 8'hFF);
    rd(ADDR_LANES_HI, 8'hFF);
    chk("pin", 16'h0000, {15'h0000, calibration_status_pin});
    chk("summary", 16'h0000, {15'h0000, alarm_summary});
    // reserved bits, read-only summary and an unmapped place
    wr(ADDR_DISABLES, 8'hFF);
    rd(ADDR_DISABLES, 8'h3F);
    wr(ADDR_SUMMARY, 8'hFF);
    rd(12'h2C3, 8'h00);
    // clear everything once the link is up
    wr(ADDR_FLAGS, 8'hFF);
    wr(ADDR_LANES_LO, 8'hFF);
    wr(ADDR_LANES_HI, 8'hFF);
    wr(ADDR_DISABLES, 8'h00);
    rd(ADDR_FLAGS, 8'h00);
    rd(ADDR_LANES_LO, 8'h00);
    rd(ADDR_LANES_HI, 8'h00);
    rd(ADDR_SUMMARY, 8'h00);
    for (int i = 0; i < 10; i++) begin
      lane = $urandom_range(15, 0);
      lanes = 16'h0001 << lane;
      lane_active = 16'($urandom) | lanes;
      err_pat = lanes | (~lane_active & 16'($urandom));
      calibration_status_sel = 1'($urandom_range(1, 0));
      calibration_status_in = 1'($urandom_range(1, 0));
      @(negedge clk);
      cause(i, 1'b1);
      @(negedge clk);
      cause(i, 1'b0);
      chk("pin", {15'h0000, calibration_status_sel | calibration_status_in}, {15'h0000, calibration_status_pin});
      chk("summary", 16'h0001, {15'h0000, alarm_summary});
      rd(ADDR_FLAGS, 8'h01 << flag_bit[i]);
      rd(ADDR_SUMMARY, 8'h01);
      rd(ADDR_LANES_LO, i == 0 ? lanes[7:0] : 8'h00);
      rd(ADDR_LANES_HI, i == 0 ? lanes[15:8] : 8'h00);
      wr(ADDR_FLAGS, 8'h01 << flag_bit[i]);
      rd(ADDR_FLAGS, 8'h00);
      rd(ADDR_LANES_LO, 8'h00);
      rd(ADDR_LANES_HI, 8'h00);
      rd(ADDR_SUMMARY, 8'h00);
    end
    // lane bytes clear on their own while the flag stays
    @(negedge clk);
    cause(0, 1'b1);
    @(negedge clk);
    cause(0, 1'b0);
    wr(ADDR_LANES_LO, lanes[7:0]);
    wr(ADDR_LANES_HI, lanes[15:8]);
    rd(ADDR_LANES_LO, 8'h00);
    rd(ADDR_LANES_HI, 8'h00);
    rd(ADDR_FLAGS, 8'h20);
    wr(ADDR_FLAGS, 8'h20);
    // a standing condition outlives the clearing write
    pll_locked = 1'b0;
    wr(ADDR_FLAGS, 8'h10);
    rd(ADDR_FLAGS, 8'h10);
    pll_locked = 1'b1;
    wr(ADDR_FLAGS, 8'h10);
    rd(ADDR_FLAGS, 8'h00);
    sreset();
    rd(ADDR_FLAGS, 8'h3F);
    rd(ADDR_LANES_HI, 8'hFF);
    // each disable bit hides exactly its own flag
    for (int b = 0; b < 6; b++) begin
      sreset();
      wr(ADDR_FLAGS, 8'h3F ^ (8'h01 << b));
      wr(ADDR_DISABLES, 8'h01 << b);
      rd(ADDR_SUMMARY, 8'h00);
      wr(ADDR_DISABLES, 8'h3F ^ (8'h01 << b));
      rd(ADDR_SUMMARY, 8'h01);
    end
    for (k = 0; k < 20 && exp_q.size() > 0; k++) @(negedge clk);
    if (exp_q.size() != 0) chk("pending reads", 16'h0000, 16'(exp_q.size()));
    end_sim();
  end
endmodule
`default_nettype wire
